/* src/blit_param_defines.svh */
`ifndef BLIT_PARAM_DEFINES_SVH
`define BLIT_PARAM_DEFINES_SVH

// memory-mapped offsets of the parameter registers
`define OFS_WIDTH_LOW       8'h08
`define OFS_WIDTH_HIGH      8'h09
`define OFS_HEIGHT_LOW      8'h0a
`define OFS_HEIGHT_HIGH     8'h0b
`define OFS_DPITCH_LOW      8'h0c
`define OFS_DPITCH_HIGH     8'h0d
`define OFS_SPITCH_LOW      8'h0e
`define OFS_SPITCH_HIGH     8'h0f
`define OFS_DSTART_B0       8'h10
`define OFS_DSTART_B1       8'h11
`define OFS_DSTART_B2       8'h12
`define OFS_SSTART_B0       8'h14
`define OFS_SSTART_B1       8'h15
`define OFS_SSTART_B2       8'h16
`define OFS_WRITE_MASK      8'h17

// field widths, full and reduced variants
`define WIDTH_BITS_FULL     13
`define WIDTH_BITS_RED      11
`define HEIGHT_BITS_FULL    11
`define HEIGHT_BITS_RED     10
`define PITCH_BITS          13
`define START_BITS_FULL     22
`define START_BITS_RED      21

// write-mask register fields
`define WMASK_DEST_LSB      0
`define WMASK_DEST_MSB      2
`define WMASK_P24_LSB       3
`define WMASK_P24_MSB       4
`define WMASK_DWPTR_LSB     5
`define WMASK_DWPTR_MSB     6
`define WMASK_IMPL          8'h7f

`define RESET_BYTE          8'h00

`endif

/* src/blit_param_pkg.sv */
package blit_param_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [2:0] {
		ENG_IDLE   = 3'b001,
		ENG_BUSY   = 3'b010,
		ENG_FINISH = 3'b100
	} engine_state_e;
endpackage

/* src/byte_field_reg.sv */
`timescale 1ns/100ps
`include "blit_param_defines.svh"

// one field spread over byte registers: pending copy written by software,
// working copy loaded when a transfer starts
module byte_field_reg #(
	parameter int NBYTES   = 2,
	parameter int IMPL     = 13,
	parameter bit BUFFERED = 1'b1
) (
	// clock and reset
	input  wire logic                  clk_sys_i,
	input  wire logic                  reset_n_i,
	// software side
	input  wire logic                  wr_en_i,
	input  wire logic [1:0]            wr_byte_i,
	input  wire logic [7:0]            wr_data_i,
	input  wire logic [1:0]            rd_byte_i,
	output logic      [7:0]            rd_data_o,
	// engine side
	input  wire logic                  load_i,
	output logic      [NBYTES*8-1:0]   work_o
);
	localparam logic [NBYTES*8-1:0] MASK = {NBYTES*8{1'b1}} >> (NBYTES*8-IMPL);

	logic [NBYTES*8-1:0] pending;
	logic [NBYTES*8-1:0] next_pending;

	always_comb begin
		next_pending = pending;
		next_pending[wr_byte_i*8 +: 8] = wr_data_i;
		next_pending = next_pending & MASK;
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			pending <= '0;
		end else if (wr_en_i) begin
			pending <= next_pending;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			work_o <= '0;
		end else if (!BUFFERED) begin
			work_o <= wr_en_i ? next_pending : pending;
		end else if (load_i) begin
			work_o <= pending;
		end
	end

	assign rd_data_o = pending[rd_byte_i*8 +: 8];
endmodule

/* src/blit_parameter_registers.sv */
`timescale 1ns/100ps
`include "blit_param_defines.svh"

module blit_parameter_registers #(
	parameter bit REDUCED = 1'b0
) (
	// clock and reset
	input  wire logic                         clk_sys_i,
	input  wire logic                         reset_n_i,
	// indexed register port, offsets as memory-mapped window
	input  wire logic                         reg_wr_i,
	input  wire logic [7:0]                   reg_addr_i,
	input  wire logic [7:0]                   reg_wdata_i,
	output logic      [7:0]                   reg_rdata_o,
	// transfer control
	input  wire logic                         start_i,
	input  wire logic                         autostart_en_i,
	input  wire logic                         engine_done_i,
	output logic                              buffered_status_o,
	output logic                              engine_busy_o,
	output logic                              transfer_start_o,
	// working parameters toward the engine core
	output logic      [`WIDTH_BITS_FULL-1:0]  width_o,
	output logic      [`HEIGHT_BITS_FULL-1:0] height_o,
	output logic      [`PITCH_BITS-1:0]       dest_pitch_o,
	output logic      [`PITCH_BITS-1:0]       src_pitch_o,
	output logic      [`START_BITS_FULL-1:0]  dest_start_o,
	output logic      [`START_BITS_FULL-1:0]  src_start_o,
	output logic      [2:0]                   dest_write_mask_o,
	output logic      [1:0]                   packed24_mask_o,
	output logic      [1:0]                   dword_pointer_o,
	output logic      [4:0]                   skip_count_o
);
	import blit_param_pkg::*;

	localparam int W_IMPL = REDUCED ? `WIDTH_BITS_RED : `WIDTH_BITS_FULL;
	localparam int H_IMPL = REDUCED ? `HEIGHT_BITS_RED : `HEIGHT_BITS_FULL;
	localparam int S_IMPL = REDUCED ? `START_BITS_RED : `START_BITS_FULL;
	localparam bit BUF    = !REDUCED;

	engine_state_e state;
	engine_state_e next_state;
	logic          load;
	logic          set_waiting;
	logic [7:0]    write_mask;

	// per-field decode: which field, which byte
	logic [5:0]    wr_sel;
	logic [1:0]    byte_idx;
	logic [7:0]    rd_w, rd_h, rd_dp, rd_sp, rd_ds, rd_ss;
	logic [15:0]   w_full, h_full, dp_full, sp_full;
	logic [23:0]   ds_full, ss_full;

	function automatic logic in_range(input logic [7:0] a, input logic [7:0] base,
		input logic [7:0] n);
		in_range = (a >= base) && (a < base + n);
	endfunction

	always_comb begin
		wr_sel   = 6'b00_0000;
		byte_idx = 2'd0;
		if (in_range(reg_addr_i, `OFS_WIDTH_LOW, 8'd2)) begin
			wr_sel[0] = 1'b1;
			byte_idx  = 2'(reg_addr_i - `OFS_WIDTH_LOW);
		end else if (in_range(reg_addr_i, `OFS_HEIGHT_LOW, 8'd2)) begin
			wr_sel[1] = 1'b1;
			byte_idx  = 2'(reg_addr_i - `OFS_HEIGHT_LOW);
		end else if (in_range(reg_addr_i, `OFS_DPITCH_LOW, 8'd2)) begin
			wr_sel[2] = 1'b1;
			byte_idx  = 2'(reg_addr_i - `OFS_DPITCH_LOW);
		end else if (in_range(reg_addr_i, `OFS_SPITCH_LOW, 8'd2)) begin
			wr_sel[3] = 1'b1;
			byte_idx  = 2'(reg_addr_i - `OFS_SPITCH_LOW);
		end else if (in_range(reg_addr_i, `OFS_DSTART_B0, 8'd3)) begin
			wr_sel[4] = 1'b1;
			byte_idx  = 2'(reg_addr_i - `OFS_DSTART_B0);
		end else if (in_range(reg_addr_i, `OFS_SSTART_B0, 8'd3)) begin
			wr_sel[5] = 1'b1;
			byte_idx  = 2'(reg_addr_i - `OFS_SSTART_B0);
		end
	end

	// width, low byte then upper five bits (three when REDUCED)
	byte_field_reg #(.NBYTES(2), .IMPL(W_IMPL), .BUFFERED(BUF)) u_width (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.wr_en_i   (reg_wr_i && wr_sel[0]),
		.wr_byte_i (byte_idx),
		.wr_data_i (reg_wdata_i),
		.rd_byte_i (byte_idx),
		.rd_data_o (rd_w),
		.load_i    (load),
		.work_o    (w_full)
	);

	// height is always double-buffered; the engine never writes it back
	byte_field_reg #(.NBYTES(2), .IMPL(H_IMPL), .BUFFERED(1'b1)) u_height (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.wr_en_i   (reg_wr_i && wr_sel[1]),
		.wr_byte_i (byte_idx),
		.wr_data_i (reg_wdata_i),
		.rd_byte_i (byte_idx),
		.rd_data_o (rd_h),
		.load_i    (load),
		.work_o    (h_full)
	);

	// destination pitch
	byte_field_reg #(.NBYTES(2), .IMPL(`PITCH_BITS), .BUFFERED(BUF)) u_dpitch (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.wr_en_i   (reg_wr_i && wr_sel[2]),
		.wr_byte_i (byte_idx),
		.wr_data_i (reg_wdata_i),
		.rd_byte_i (byte_idx),
		.rd_data_o (rd_dp),
		.load_i    (load),
		.work_o    (dp_full)
	);

	// source pitch; low three high-byte bits are software's concern
	byte_field_reg #(.NBYTES(2), .IMPL(`PITCH_BITS), .BUFFERED(BUF)) u_spitch (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.wr_en_i   (reg_wr_i && wr_sel[3]),
		.wr_byte_i (byte_idx),
		.wr_data_i (reg_wdata_i),
		.rd_byte_i (byte_idx),
		.rd_data_o (rd_sp),
		.load_i    (load),
		.work_o    (sp_full)
	);

	// destination start, three bytes
	byte_field_reg #(.NBYTES(3), .IMPL(S_IMPL), .BUFFERED(BUF)) u_dstart (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.wr_en_i   (reg_wr_i && wr_sel[4]),
		.wr_byte_i (byte_idx),
		.wr_data_i (reg_wdata_i),
		.rd_byte_i (byte_idx),
		.rd_data_o (rd_ds),
		.load_i    (load),
		.work_o    (ds_full)
	);

	// source start; any write to its byte 0 is simply stored
	byte_field_reg #(.NBYTES(3), .IMPL(S_IMPL), .BUFFERED(BUF)) u_sstart (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.wr_en_i   (reg_wr_i && wr_sel[5]),
		.wr_byte_i (byte_idx),
		.wr_data_i (reg_wdata_i),
		.rd_byte_i (byte_idx),
		.rd_data_o (rd_ss),
		.load_i    (load),
		.work_o    (ss_full)
	);

	// write mask, bit 7 reserved and reads zero
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			write_mask <= `RESET_BYTE;
		end else if (reg_wr_i && reg_addr_i == `OFS_WRITE_MASK) begin
			write_mask <= reg_wdata_i & `WMASK_IMPL;
		end
	end

	// read mux
	always_comb begin
		case (1'b1)
			wr_sel[0]: reg_rdata_o = rd_w;
			wr_sel[1]: reg_rdata_o = rd_h;
			wr_sel[2]: reg_rdata_o = rd_dp;
			wr_sel[3]: reg_rdata_o = rd_sp;
			wr_sel[4]: reg_rdata_o = rd_ds;
			wr_sel[5]: reg_rdata_o = rd_ss;
			default:   reg_rdata_o = (reg_addr_i == `OFS_WRITE_MASK) ? write_mask : 8'h00;
		endcase
	end

	// a set waits from any parameter write until a transfer takes it
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			set_waiting <= 1'b0;
		end else if (reg_wr_i && (wr_sel != 6'b00_0000 || reg_addr_i == `OFS_WRITE_MASK)) begin
			set_waiting <= 1'b1;
		end else if (load) begin
			set_waiting <= 1'b0;
		end
	end

	// explicit start, or autostart when idle with a set waiting
	assign load = (state == ENG_IDLE) && (start_i || (autostart_en_i && set_waiting));

	always_comb begin
		case (state)
			ENG_IDLE:   next_state = load ? ENG_BUSY : ENG_IDLE;
			ENG_BUSY:   next_state = engine_done_i ? ENG_FINISH : ENG_BUSY;
			ENG_FINISH: next_state = ENG_IDLE;
			default:    next_state = ENG_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state <= ENG_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			transfer_start_o  <= 1'b0;
			dest_write_mask_o <= 3'd0;
			packed24_mask_o   <= 2'd0;
			dword_pointer_o   <= 2'd0;
			skip_count_o      <= 5'd0;
		end else begin
			transfer_start_o <= load;
			if (load) begin
				dest_write_mask_o <= write_mask[`WMASK_DEST_MSB:`WMASK_DEST_LSB];
				packed24_mask_o   <= write_mask[`WMASK_P24_MSB:`WMASK_P24_LSB];
				dword_pointer_o   <= write_mask[`WMASK_DWPTR_MSB:`WMASK_DWPTR_LSB];
				// leading pixels (or packed-24 bytes) left unwritten per line
				skip_count_o      <= write_mask[4:0];
			end
		end
	end

	assign buffered_status_o = set_waiting && (state != ENG_IDLE);
	assign engine_busy_o     = (state != ENG_IDLE);
	assign width_o           = w_full[`WIDTH_BITS_FULL-1:0];
	assign height_o          = h_full[`HEIGHT_BITS_FULL-1:0];
	assign dest_pitch_o      = dp_full[`PITCH_BITS-1:0];
	assign src_pitch_o       = sp_full[`PITCH_BITS-1:0];
	assign dest_start_o      = ds_full[`START_BITS_FULL-1:0];
	assign src_start_o       = ss_full[`START_BITS_FULL-1:0];
endmodule

/* tb/blit_param_checker.sv */
`timescale 1ns/100ps
`include "blit_param_defines.svh"

module blit_param_checker #(
	parameter bit REDUCED = 1'b0
) (
	// clock and reset
	input wire logic                         clk_sys_i,
	input wire logic                         reset_n_i,
	// register port and control
	input wire logic                         start_i,
	input wire logic [7:0]                   reg_addr_i,
	input wire logic [7:0]                   reg_rdata_o,
	input wire logic                         buffered_status_o,
	input wire logic                         engine_busy_o,
	input wire logic                         transfer_start_o,
	// working set
	input wire logic [`WIDTH_BITS_FULL-1:0]  width_o,
	input wire logic [`HEIGHT_BITS_FULL-1:0] height_o,
	input wire logic [`START_BITS_FULL-1:0]  src_start_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	a_start_one_pulse: assert property (transfer_start_o |=> !transfer_start_o)
		else $error("start pulse longer than one cycle");
	a_start_when_idle: assert property (start_i && !engine_busy_o |=> transfer_start_o && engine_busy_o)
		else $error("idle start not taken");
	// past reset guard: a one-edge reset would otherwise look like a change
	// reduced parts buffer only height and the write-mask fields, so their other working fields follow writes
	a_work_set_held: assert property (!REDUCED && reset_n_i && $past(reset_n_i) && !transfer_start_o |-> $stable(width_o) && $stable(src_start_o))
		else $error("working set moved without a start");
	a_height_set_held: assert property (reset_n_i && $past(reset_n_i) && !transfer_start_o |-> $stable(height_o))
		else $error("height moved without a start");
	a_wait_needs_busy: assert property (buffered_status_o |-> engine_busy_o)
		else $error("waiting flag while idle");
	a_unmapped_read_zero: assert property (reg_addr_i == 8'h13 || reg_addr_i == 8'h18 |-> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_width_top_zero: assert property (reg_addr_i == 8'h09 |-> reg_rdata_o[7:5] == 3'b000)
		else $error("width high byte extra bits");
	a_height_top_zero: assert property (reg_addr_i == 8'h0b |-> reg_rdata_o[7:3] == 5'h00)
		else $error("height high byte extra bits");
	a_start_top_zero: assert property (reg_addr_i == 8'h12 || reg_addr_i == 8'h16 |-> reg_rdata_o[7:6] == 2'b00)
		else $error("start top byte extra bits");
	a_mask_rsvd_zero: assert property (reg_addr_i == 8'h17 |-> !reg_rdata_o[7])
		else $error("mask reserved bit set");
endmodule

bind blit_parameter_registers blit_param_checker #(.REDUCED(REDUCED)) u_blit_param_checker (.*);

/* tb/tb.sv */
`timescale 1ns/100ps

module tb;
	import blit_param_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        reset_n_i, reg_wr_i, start_i, autostart_en_i, engine_done_i;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic        buffered_status_o, engine_busy_o, transfer_start_o;
	logic [12:0] width_o, dest_pitch_o, src_pitch_o;
	logic [10:0] height_o;
	logic [21:0] dest_start_o, src_start_o;
	logic [2:0]  dest_write_mask_o;
	logic [1:0]  packed24_mask_o, dword_pointer_o;
	logic [4:0]  skip_count_o;
	byte_t       sh [8'h08:8'h17];
	byte_t       wk [8'h08:8'h17];
	int          fail_count = 0;
	int          comparisons = 0;
	int          seed;
	logic [7:0]  red_rdata;

	blit_parameter_registers u_blit_parameter_registers (.*);

	// reduced variant on the same register bus, read back only
	blit_parameter_registers #(.REDUCED(1'b1)) u_blit_parameter_registers_red (
		.clk_sys_i         (clk_sys_i),
		.reset_n_i         (reset_n_i),
		.reg_wr_i          (reg_wr_i),
		.reg_addr_i        (reg_addr_i),
		.reg_wdata_i       (reg_wdata_i),
		.reg_rdata_o       (red_rdata),
		.start_i           (start_i),
		.autostart_en_i    (autostart_en_i),
		.engine_done_i     (engine_done_i),
		.buffered_status_o (),
		.engine_busy_o     (),
		.transfer_start_o  (),
		.width_o           (),
		.height_o          (),
		.dest_pitch_o      (),
		.src_pitch_o       (),
		.dest_start_o      (),
		.src_start_o       (),
		.dest_write_mask_o (),
		.packed24_mask_o   (),
		.dword_pointer_o   (),
		.skip_count_o      ()
	);

	always #2.5 clk_sys_i = ~clk_sys_i;

	// bits a register keeps on the full variant
	function automatic byte_t msk(input byte_t a);
		case (a)
			8'h09, 8'h0d, 8'h0f: return 8'h1f;
			8'h0b: return 8'h07;
			8'h12, 8'h16: return 8'h3f;
			8'h17: return 8'h7f;
			8'h13: return 8'h00;
			default: return 8'hff;
		endcase
	endfunction

	// bits a register keeps on the reduced variant
	function automatic byte_t msk_red(input byte_t a);
		case (a)
			8'h09: return 8'h07;
			8'h0b: return 8'h03;
			8'h12, 8'h16: return 8'h1f;
			default: return 8'hff;
		endcase
	endfunction

	task conclude;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task wr(input byte_t a, input byte_t d);
		@(negedge clk_sys_i);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		@(negedge clk_sys_i);
		reg_wr_i = 1'b0;
		sh[a] = d & msk(a);
	endtask

	task rd(input byte_t a);
		reg_addr_i = a;
		#1;
		chk(reg_rdata_o, sh[a]);
		chk(red_rdata, sh[a] & msk_red(a));
	endtask

	task chk_work;
		chk(width_o, {wk[8'h09][4:0], wk[8'h08]});
		chk(height_o, {wk[8'h0b][2:0], wk[8'h0a]});
		chk(dest_pitch_o, {wk[8'h0d][4:0], wk[8'h0c]});
		chk(src_pitch_o, {wk[8'h0f][4:0], wk[8'h0e]});
		chk(dest_start_o, {wk[8'h12][5:0], wk[8'h11], wk[8'h10]});
		chk(src_start_o, {wk[8'h16][5:0], wk[8'h15], wk[8'h14]});
		chk({dword_pointer_o, packed24_mask_o, dest_write_mask_o}, wk[8'h17]);
		chk(skip_count_o, wk[8'h17][4:0]);
	endtask

	task wait_start;
		int n;
		for (n = 0; n < 8 && transfer_start_o !== 1'b1; n++) @(negedge clk_sys_i);
		if (n == 8) begin
			fail_count++;
			conclude();
		end
		wk = sh;
	endtask

	task kick;
		@(negedge clk_sys_i);
		start_i = 1'b1;
		@(negedge clk_sys_i);
		start_i = 1'b0;
		wait_start();
	endtask

	// done pulse, then the engine passes its finish cycle back to idle
	task finish_eng;
		int n;
		@(negedge clk_sys_i);
		engine_done_i = 1'b1;
		@(negedge clk_sys_i);
		engine_done_i = 1'b0;
		for (n = 0; n < 8 && engine_busy_o !== 1'b0; n++) @(negedge clk_sys_i);
		if (n == 8) begin
			fail_count++;
			conclude();
		end
	endtask

	initial begin
		reset_n_i = 1'b0;
		reg_wr_i = 1'b0;
		reg_addr_i = 8'h08;
		reg_wdata_i = 8'h00;
		start_i = 1'b0;
		autostart_en_i = 1'b0;
		engine_done_i = 1'b0;
		seed = $urandom(32'haf24_91b8);
		foreach (sh[i]) sh[i] = 8'h00;
		wk = sh;
		repeat (2) @(negedge clk_sys_i);
		reset_n_i = 1'b1;
		foreach (sh[i]) rd(i);
		reg_addr_i = 8'h18;
		#1;
		chk(reg_rdata_o, 8'h00);
		for (int r = 0; r < 3; r++) begin
			for (int a = 8'h08; a <= 8'h17; a++) wr(8'(a), (r == 0) ? 8'hff : 8'($urandom));
			if (r == 2) begin
				wr(8'h0d, 8'($urandom) & 8'hf8);
				wr(8'h0f, 8'($urandom) & 8'hf8);
				wr(8'h14, 8'($urandom));
			end
			foreach (sh[i]) rd(i);
			chk_work();
			kick();
			chk_work();
			// a second start while busy must be ignored
			@(negedge clk_sys_i);
			start_i = 1'b1;
			repeat (3) @(negedge clk_sys_i);
			start_i = 1'b0;
			chk(transfer_start_o, 1'b0);
			wr(8'h08, 8'($urandom));
			chk(buffered_status_o, 1'b1);
			chk_work();
			finish_eng();
			chk(buffered_status_o, 1'b0);
		end
		autostart_en_i = 1'b1;
		wait_start();
		chk_work();
		autostart_en_i = 1'b0;
		finish_eng();
		kick();
		chk_work();
		finish_eng();
		conclude();
	end
endmodule
